// ==== hdl/afss_consts.vh ====
// constants for the autofocus stepper sequencer
// Overview of operation
// - control bit 2 low holds step counter reset
// - step code sits in control bits 7..3
// - steps moved equal twice code plus two
// - config bits 2..0 pick hold pulse count
// - focus hold pulse 2 ms or 1 ms
// - home hold pulse 10 ms or 5 ms
// - config bit 3 picks 2-phase or 1-2 phase
// - config bit 4 enables home position sequence
// - config bit 5 adds 64 extra steps
// - config bit 7 reads running flag
// - running flag clears itself at sequence end
// - focus sequence steps at 500 pps
// - home sequence steps at 100 pps
`ifndef AFSS_CONSTS_VH
`define AFSS_CONSTS_VH

`define AFSS_SLAVE_ADDR     7'h32
`define AFSS_ADDR_CTRL      8'h00
`define AFSS_ADDR_CFG       8'h01
`define AFSS_CTRL_RESET     8'h00
`define AFSS_CFG_RESET      6'h00

`define AFSS_CTRL_DIR       0
`define AFSS_CTRL_ON        1
`define AFSS_CTRL_CRST      2
`define AFSS_CTRL_CODE_LO   3
`define AFSS_CTRL_CODE_HI   7
`define AFSS_CFG_HOLD_LO    0
`define AFSS_CFG_HOLD_HI    2
`define AFSS_CFG_EXC        3
`define AFSS_CFG_HOME       4
`define AFSS_CFG_PLUS64     5
`define AFSS_CFG_FLAG       7

`define AFSS_CLK_MHZ        40
`define AFSS_AF_PPS         500
`define AFSS_HOME_PPS       100
`define AFSS_AF_HOLD2_US    2000
`define AFSS_AF_HOLD12_US   1000
`define AFSS_HOME_HOLD2_US  10000
`define AFSS_HOME_HOLD12_US 5000
`define AFSS_EXTRA_STEPS    8'h40

`endif

// ==== hdl/afss_i2c_slave.v ====
// byte-wide register port reached over the two-wire serial link
`timescale 1ns/100ps
`default_nettype none
`include "afss_consts.vh"
module afss_i2c_slave (
   // clock, reset, enable
   input  wire       clk_in,
   input  wire       rst_n_in,
   input  wire       ce_in,
   // link pins
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_oe_out,
   // register side
   input  wire [7:0] rd_data_in,
   output reg  [7:0] rd_addr_out,
   output reg        wr_stb_out,
   output reg  [7:0] wr_addr_out,
   output reg  [7:0] wr_data_out
);
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_ADDR = 7'h02;
   localparam [6:0] S_PTR  = 7'h04;
   localparam [6:0] S_WDAT = 7'h08;
   localparam [6:0] S_ACK  = 7'h10;
   localparam [6:0] S_TX   = 7'h20;
   localparam [6:0] S_MACK = 7'h40;

   reg [2:0] scl_s_q;
   reg [2:0] sda_s_q;
   reg       scl_f_q;
   reg       sda_f_q;
   reg       scl_p_q;
   reg       sda_p_q;
   reg [6:0] st_q;
   reg [6:0] nxt_q;
   reg [3:0] cnt_q;
   reg [7:0] sh_q;
   reg       nack_q;

   wire start_w = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
   wire stop_w  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
   wire rise_w  = scl_f_q & ~scl_p_q;
   wire fall_w  = ~scl_f_q & scl_p_q;

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         scl_s_q     <= 3'h7;
         sda_s_q     <= 3'h7;
         scl_f_q     <= 1'b1;
         sda_f_q     <= 1'b1;
         scl_p_q     <= 1'b1;
         sda_p_q     <= 1'b1;
         st_q        <= S_IDLE;
         nxt_q       <= S_IDLE;
         cnt_q       <= 4'h0;
         sh_q        <= 8'h00;
         nack_q      <= 1'b0;
         sda_oe_out  <= 1'b0;
         rd_addr_out <= 8'h00;
         wr_stb_out  <= 1'b0;
         wr_addr_out <= 8'h00;
         wr_data_out <= 8'h00;
      end else if (ce_in) begin
         scl_s_q <= {scl_s_q[1:0], scl_in};
         sda_s_q <= {sda_s_q[1:0], sda_in};
         // a level is taken only once the last two stages agree
         if (scl_s_q[1] == scl_s_q[2]) begin
            scl_f_q <= scl_s_q[2];
         end
         if (sda_s_q[1] == sda_s_q[2]) begin
            sda_f_q <= sda_s_q[2];
         end
         scl_p_q    <= scl_f_q;
         sda_p_q    <= sda_f_q;
         wr_stb_out <= 1'b0;
         if (start_w) begin
            st_q       <= S_ADDR;
            cnt_q      <= 4'h0;
            sda_oe_out <= 1'b0;
         end else if (stop_w) begin
            st_q       <= S_IDLE;
            sda_oe_out <= 1'b0;
         end else if (rise_w) begin
            cnt_q <= cnt_q + 4'h1;
            if ((st_q == S_ADDR) || (st_q == S_PTR) || (st_q == S_WDAT)) begin
               sh_q <= {sh_q[6:0], sda_f_q};
            end
            if (st_q == S_MACK) begin
               nack_q <= sda_f_q;
            end
         end else if (fall_w) begin
            case (st_q)
               S_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     if (sh_q[7:1] == `AFSS_SLAVE_ADDR) begin
                        sda_oe_out <= 1'b1;
                        st_q       <= S_ACK;
                        nxt_q      <= sh_q[0] ? S_TX : S_PTR;
                     end else begin
                        st_q <= S_IDLE;
                     end
                  end
               end
               S_PTR: begin
                  if (cnt_q == 4'h8) begin
                     cnt_q       <= 4'h0;
                     rd_addr_out <= sh_q;
                     sda_oe_out  <= 1'b1;
                     st_q        <= S_ACK;
                     nxt_q       <= S_WDAT;
                  end
               end
               S_WDAT: begin
                  if (cnt_q == 4'h8) begin
                     cnt_q       <= 4'h0;
                     wr_stb_out  <= 1'b1;
                     wr_addr_out <= rd_addr_out;
                     wr_data_out <= sh_q;
                     rd_addr_out <= rd_addr_out + 8'h01;
                     sda_oe_out  <= 1'b1;
                     st_q        <= S_ACK;
                     nxt_q       <= S_WDAT;
                  end
               end
               S_ACK, S_MACK: begin
                  cnt_q <= 4'h0;
                  if ((st_q == S_MACK) && nack_q) begin
                     sda_oe_out <= 1'b0;
                     st_q       <= S_IDLE;
                  end else if ((st_q == S_MACK) || (nxt_q == S_TX)) begin
                     // pointer advances as each byte is loaded for sending
                     sh_q        <= rd_data_in;
                     sda_oe_out  <= ~rd_data_in[7];
                     rd_addr_out <= rd_addr_out + 8'h01;
                     st_q        <= S_TX;
                  end else begin
                     sda_oe_out <= 1'b0;
                     st_q       <= nxt_q;
                  end
               end
               S_TX: begin
                  if (cnt_q == 4'h8) begin
                     sda_oe_out <= 1'b0;
                     st_q       <= S_MACK;
                  end else begin
                     sh_q       <= {sh_q[6:0], 1'b0};
                     sda_oe_out <= ~sh_q[6];
                  end
               end
               default: begin
                  st_q <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== hdl/afss_sequencer.v ====
// autofocus and home position stepping sequencer with its two registers
`timescale 1ns/100ps
`default_nettype none
`include "afss_consts.vh"
module afss_sequencer #(
   parameter [19:0] AF_STEP_CYC     = (`AFSS_CLK_MHZ * 1000000) / `AFSS_AF_PPS,
   parameter [19:0] HOME_STEP_CYC   = (`AFSS_CLK_MHZ * 1000000) / `AFSS_HOME_PPS,
   parameter [19:0] AF_HOLD2_CYC    = `AFSS_AF_HOLD2_US * `AFSS_CLK_MHZ,
   parameter [19:0] AF_HOLD12_CYC   = `AFSS_AF_HOLD12_US * `AFSS_CLK_MHZ,
   parameter [19:0] HOME_HOLD2_CYC  = `AFSS_HOME_HOLD2_US * `AFSS_CLK_MHZ,
   parameter [19:0] HOME_HOLD12_CYC = `AFSS_HOME_HOLD12_US * `AFSS_CLK_MHZ
) (
   // clock, reset, enable
   input  wire       clk_in,
   input  wire       rst_n_in,
   input  wire       ce_in,
   // serial link pins
   input  wire       scl_in,
   input  wire       sda_in,
   output reg        sda_out,
   output wire       sda_oe_out,
   // motor bridge and status
   output reg  [3:0] bridge_out,
   output reg        running_out,
   output reg  [7:0] step_count_out
);
   localparam [3:0] Q_IDLE  = 4'h1;
   localparam [3:0] Q_HOLDF = 4'h2;
   localparam [3:0] Q_STEP  = 4'h4;
   localparam [3:0] Q_HOLDR = 4'h8;

   reg  [7:0]  ctrl_q;
   reg  [5:0]  cfg_q;
   reg  [3:0]  st_q;
   reg  [19:0] tmr_q;
   reg  [5:0]  holds_q;
   reg  [7:0]  left_q;
   reg  [2:0]  phase_q;
   reg         home_q;
   reg         half_q;
   reg         dir_q;
   reg  [7:0]  rd_data_d;
   wire [7:0]  rd_addr_w;
   wire        wr_stb_w;
   wire [7:0]  wr_addr_w;
   wire [7:0]  wr_data_w;

   // hold pulse count per select code
   function [5:0] hold_count;
      input [2:0] code;
      begin
         case (code)
            3'h1:    hold_count = 6'h02;
            3'h2:    hold_count = 6'h04;
            3'h3:    hold_count = 6'h05;
            3'h4:    hold_count = 6'h08;
            3'h5:    hold_count = 6'h10;
            3'h6:    hold_count = 6'h20;
            default: hold_count = 6'h01;
         endcase
      end
   endfunction

   // bridge levels OUT1..OUT4 per half-step; even entries form the 2-phase cycle
   function [3:0] phase_bits;
      input [2:0] ph;
      begin
         case (ph)
            3'h0:    phase_bits = 4'hA;
            3'h1:    phase_bits = 4'h2;
            3'h2:    phase_bits = 4'h6;
            3'h3:    phase_bits = 4'h4;
            3'h4:    phase_bits = 4'h5;
            3'h5:    phase_bits = 4'h1;
            3'h6:    phase_bits = 4'h9;
            default: phase_bits = 4'h8;
         endcase
      end
   endfunction

   afss_i2c_slave u_link (
      .clk_in      (clk_in),
      .rst_n_in    (rst_n_in),
      .ce_in       (ce_in),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .sda_oe_out  (sda_oe_out),
      .rd_data_in  (rd_data_d),
      .rd_addr_out (rd_addr_w),
      .wr_stb_out  (wr_stb_w),
      .wr_addr_out (wr_addr_w),
      .wr_data_out (wr_data_w)
   );

   // launch needs the written byte to release the counter and switch on
   wire launch_w = wr_stb_w && (wr_addr_w == `AFSS_ADDR_CTRL) &&
                   wr_data_w[`AFSS_CTRL_CRST] && wr_data_w[`AFSS_CTRL_ON];
   wire [4:0] code_w = wr_data_w[`AFSS_CTRL_CODE_HI:`AFSS_CTRL_CODE_LO];
   // twice the code plus two, optionally 64 more
   wire [7:0] total_w = {2'h0, code_w, 1'b0} + 8'h02 +
                        (cfg_q[`AFSS_CFG_PLUS64] ? `AFSS_EXTRA_STEPS : 8'h00);
   wire       home_w = cfg_q[`AFSS_CFG_HOME];
   wire       half_w = cfg_q[`AFSS_CFG_EXC];
   wire [19:0] hold_start_w = home_w ? (half_w ? HOME_HOLD12_CYC : HOME_HOLD2_CYC)
                                     : (half_w ? AF_HOLD12_CYC : AF_HOLD2_CYC);
   wire [19:0] hold_cyc_w = home_q ? (half_q ? HOME_HOLD12_CYC : HOME_HOLD2_CYC)
                                   : (half_q ? AF_HOLD12_CYC : AF_HOLD2_CYC);
   wire [19:0] step_cyc_w = home_q ? HOME_STEP_CYC : AF_STEP_CYC;
   wire        tick_w     = (tmr_q == 20'h0_0000);
   wire [2:0]  delta_w    = half_q ? 3'h1 : 3'h2;

   always @* begin
      case (rd_addr_w)
         `AFSS_ADDR_CTRL: rd_data_d = ctrl_q;
         `AFSS_ADDR_CFG:  rd_data_d = {running_out, 1'b0, cfg_q};
         default:         rd_data_d = 8'h00;
      endcase
   end

   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_q         <= `AFSS_CTRL_RESET;
         cfg_q          <= `AFSS_CFG_RESET;
         st_q           <= Q_IDLE;
         tmr_q          <= 20'h0_0000;
         holds_q        <= 6'h00;
         left_q         <= 8'h00;
         phase_q        <= 3'h0;
         home_q         <= 1'b0;
         half_q         <= 1'b0;
         dir_q          <= 1'b0;
         sda_out        <= 1'b0;
         bridge_out     <= 4'h0;
         running_out    <= 1'b0;
         step_count_out <= 8'h00;
      end else if (ce_in) begin
         if (wr_stb_w && (wr_addr_w == `AFSS_ADDR_CTRL)) begin
            ctrl_q <= wr_data_w;
         end
         // running flag is read-only; settings should not move mid-sequence
         if (wr_stb_w && (wr_addr_w == `AFSS_ADDR_CFG)) begin
            cfg_q <= wr_data_w[5:0];
         end
         bridge_out <= running_out ? phase_bits(phase_q) : 4'h0;
         if (launch_w && (st_q == Q_IDLE)) begin
            // mode and excitation are latched; the rear hold count is read from cfg_q when stepping ends
            st_q           <= Q_HOLDF;
            running_out    <= 1'b1;
            home_q         <= home_w;
            half_q         <= half_w;
            dir_q          <= wr_data_w[`AFSS_CTRL_DIR];
            left_q         <= total_w;
            holds_q        <= hold_count(cfg_q[`AFSS_CFG_HOLD_HI:`AFSS_CFG_HOLD_LO]);
            tmr_q          <= hold_start_w - 20'h0_0001;
            step_count_out <= 8'h00;
         end else if (!ctrl_q[`AFSS_CTRL_CRST] || !ctrl_q[`AFSS_CTRL_ON]) begin
            // counter reset or standby aborts; only counter reset zeroes the count
            st_q        <= Q_IDLE;
            running_out <= 1'b0;
            if (!ctrl_q[`AFSS_CTRL_CRST]) begin
               step_count_out <= 8'h00;
            end
         end else if (st_q != Q_IDLE) begin
            tmr_q <= tmr_q - 20'h0_0001;
            case (st_q)
               Q_HOLDF, Q_HOLDR: begin
                  if (tick_w) begin
                     holds_q <= holds_q - 6'h01;
                     tmr_q   <= hold_cyc_w - 20'h0_0001;
                     if (holds_q == 6'h01) begin
                        if (st_q == Q_HOLDF) begin
                           st_q  <= Q_STEP;
                           tmr_q <= step_cyc_w - 20'h0_0001;
                        end else begin
                           st_q        <= Q_IDLE;
                           running_out <= 1'b0;
                        end
                     end
                  end
               end
               Q_STEP: begin
                  if (tick_w) begin
                     phase_q        <= dir_q ? phase_q - delta_w : phase_q + delta_w;
                     step_count_out <= step_count_out + 8'h01;
                     left_q         <= left_q - 8'h01;
                     tmr_q          <= step_cyc_w - 20'h0_0001;
                     if (left_q == 8'h01) begin
                        st_q    <= Q_HOLDR;
                        holds_q <= hold_count(cfg_q[`AFSS_CFG_HOLD_HI:`AFSS_CFG_HOLD_LO]);
                        tmr_q   <= hold_cyc_w - 20'h0_0001;
                     end
                  end
               end
               default: begin
                  st_q <= Q_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/afss_i2c_host.sv ====
// serial link host model that writes and reads the sequencer registers
`timescale 1ns/100ps
`default_nettype none
`include "afss_consts.vh"
module afss_i2c_host (
   // clock and resolved data wire
   input  wire logic clk_in,
   input  wire logic sda_in,
   // driven pins, data is open drain with a pull-up
   output logic      scl_out,
   output logic      sda_low_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // one system clock of 25 ns; a link bit is 5 of them low and 3 high, 200 ns in all
   task automatic q(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // the long low phase lets the device drop its ack before the clock rises again,
   // otherwise a late release while the clock is high looks like a stop
   task automatic put_bit(input logic b);
      q(2);
      sda_low_out = !b;
      q(3);
      scl_out = 1'b1;
      q(3);
      scl_out = 1'b0;
   endtask
   // sampled late in the high phase, the device sees the line through three flops
   task automatic get_bit(output logic b);
      q(2);
      sda_low_out = 1'b0;
      q(3);
      scl_out = 1'b1;
      q(3);
      b = sda_in;
      scl_out = 1'b0;
   endtask
   // also serves as repeated start: data is released first while the clock is low
   task automatic start();
      q(2);
      sda_low_out = 1'b0;
      q(3);
      scl_out = 1'b1;
      q(2);
      sda_low_out = 1'b1;
      q(2);
      scl_out = 1'b0;
   endtask
   task automatic stop();
      q(2);
      sda_low_out = 1'b1;
      q(3);
      scl_out = 1'b1;
      q(2);
      sda_low_out = 1'b0;
      q(3);
   endtask
   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
      get_bit(a);
      ack = !a;
   endtask
   task automatic wr(input logic [6:0] adr, input logic [7:0] r, input logic [7:0] v, output logic ok);
      logic a0, a1, a2;
      start();
      put_byte({adr, 1'b0}, a0);
      put_byte(r, a1);
      put_byte(v, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   task automatic rd(input logic [7:0] r, output logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start();
      put_byte({`AFSS_SLAVE_ADDR, 1'b0}, a0);
      put_byte(r, a1);
      start();
      put_byte({`AFSS_SLAVE_ADDR, 1'b1}, a2);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(1'b1);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule
`default_nettype wire

// ==== sim/afss_sequencer_asserts.sv ====
// port-level checker for the stepper sequencer
`timescale 1ns/100ps
`default_nettype none
module afss_sequencer_checker (
   // clock, reset, enable
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   input wire logic       ce_in,
   // link pins
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   // motor and status
   input wire logic [3:0] bridge_out,
   input wire logic       running_out,
   input wire logic [7:0] step_count_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_IDLE_BRIDGE: assert property (!running_out && !$past(running_out) |-> bridge_out == 4'h0)
      else $error("bridge driven while idle");
   AST_RUN_DRIVES: assert property (running_out && $past(running_out) |-> bridge_out != 4'h0)
      else $error("bridge off while running");
   AST_COUNT_STEP: assert property ($changed(step_count_out) |->
      step_count_out == $past(step_count_out) + 8'h01 || step_count_out == 8'h00)
      else $error("step count jumped");
   AST_COUNT_MAX: assert property (step_count_out <= 8'd128)
      else $error("step count above maximum");
   AST_STEP_SPACING: assert property (step_count_out != $past(step_count_out) && step_count_out != 8'h00 |=>
      ($stable(step_count_out) || step_count_out == 8'h00) [*8])
      else $error("steps too close together");
   AST_HOLD_FRONT: assert property ($rose(running_out) |-> ##1 (step_count_out == 8'h00) [*8])
      else $error("no front hold or count not cleared");
   AST_STEP_MOVES: assert property (running_out && $past(running_out) && $changed(step_count_out) |->
      ##[0:2] $changed(bridge_out))
      else $error("step without phase change");
   AST_CE_FREEZE: assert property (!ce_in |=>
      $stable(running_out) && $stable(step_count_out) && $stable(bridge_out))
      else $error("state moved with enable low");
   AST_SDA_LOW: assert property (sda_out == 1'b0)
      else $error("data pin drive value not low");
endmodule
bind afss_sequencer afss_sequencer_checker chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
   .bridge_out(bridge_out), .running_out(running_out), .step_count_out(step_count_out));
`default_nettype wire

// ==== sim/test_afss_sequencer.sv ====
// self-checking bench for the autofocus stepper sequencer
`timescale 1ns/100ps
`default_nettype none
`include "afss_consts.vh"
module test_afss_sequencer;
   localparam int AS = 40, HS = 200, AH2 = 40, AH12 = 20, HH2 = 200, HH12 = 100;
   logic       clk_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic       ce_in = 1'b1;
   logic       scl, sda_low, sda_oe, sda_drv, running, prev_run = 1'b0;
   logic [3:0] bridge;
   logic [7:0] count;
   int         run_len = 0, n_errors = 0, compares = 0;
   // open drain data line with pull-up
   wire        sda_wire = !(sda_low | sda_oe);
   always #12.5 clk_in = ~clk_in;
   afss_sequencer #(.AF_STEP_CYC(AS), .HOME_STEP_CYC(HS), .AF_HOLD2_CYC(AH2), .AF_HOLD12_CYC(AH12),
      .HOME_HOLD2_CYC(HH2), .HOME_HOLD12_CYC(HH12)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .ce_in(ce_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_drv), .sda_oe_out(sda_oe),
      .bridge_out(bridge), .running_out(running), .step_count_out(count));
   afss_i2c_host host (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_low_out(sda_low));
   always @(posedge clk_in) begin
      prev_run <= running;
      if (running && !prev_run) run_len <= 1;
      else if (running) run_len <= run_len + 1;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cw(input logic [7:0] r, input logic [7:0] v);
      logic ack;
      host.wr(`AFSS_SLAVE_ADDR, r, v, ack);
      check("write ack", ack, 1);
   endtask
   task automatic cr(input logic [7:0] r, input logic [7:0] exp);
      logic [7:0] d;
      logic ack;
      host.rd(r, d, ack);
      check("read ack", ack, 1);
      check("read data", d, exp);
   endtask
   // run length is allowed a few cycles of launch and end latency
   task automatic wait_done(input int exp_len, input logic [7:0] exp_cnt);
      int n;
      n = 0;
      while (running !== 1'b0 && n < 40000) begin
         @(negedge clk_in);
         n++;
      end
      check("run length", (run_len >= exp_len - 4 && run_len <= exp_len + 4), 1);
      check("steps issued", count, exp_cnt);
   endtask
   task automatic t_regs();
      logic ack;
      cr(8'h00, 8'h00);
      cr(8'h01, 8'h00);
      cr(8'h02, 8'h00);
      cw(8'h01, 8'hff);
      cr(8'h01, 8'h3f);
      cw(8'h01, 8'h00);
      host.wr(7'h33, 8'h00, 8'h06, ack);
      check("foreign address ack", ack, 0);
      check("no launch", running, 0);
   endtask
   // every hold code, 1-2 phase focus sequence of 2 steps
   task automatic t_holds();
      int np[8] = '{1, 2, 4, 5, 8, 16, 32, 1};
      for (int c = 0; c < 8; c++) begin
         cw(8'h01, 8'h08 | c[7:0]);
         cw(8'h00, 8'h06);
         if (c == 0) begin
            wait (count == 8'h01);
            repeat (2) @(negedge clk_in);
            check("half step pattern", bridge, 4'h2);
         end
         wait_done(2 * np[c] * AH12 + 2 * AS, 8'd2);
      end
   endtask
   task automatic t_full();
      cw(8'h01, 8'h01);
      cw(8'h00, 8'hfe);
      check("rest pattern", bridge, 4'ha);
      wait (count == 8'h01);
      repeat (2) @(negedge clk_in);
      check("full step pattern", bridge, 4'h6);
      wait_done(2 * 2 * AH2 + 64 * AS, 8'd64);
   endtask
   task automatic t_home();
      cw(8'h01, 8'h38);
      cw(8'h00, 8'h0e);
      cr(8'h01, 8'hb8);
      wait_done(2 * HH12 + 68 * HS, 8'd68);
      cr(8'h01, 8'h38);
      cw(8'h01, 8'h30);
      cw(8'h00, 8'h06);
      wait_done(2 * HH2 + 66 * HS, 8'd66);
   endtask
   task automatic t_abort();
      logic [7:0] c;
      cw(8'h01, 8'h00);
      cw(8'h00, 8'hff);
      wait (count == 8'h01);
      repeat (2) @(negedge clk_in);
      check("reverse pattern", bridge, 4'h9);
      // freeze well clear of a step so the phase update is not split
      wait (count == 8'h05);
      repeat (4) @(negedge clk_in);
      ce_in = 1'b0;
      c = count;
      repeat (30) @(negedge clk_in);
      check("frozen count", count, c);
      ce_in = 1'b1;
      cw(8'h00, 8'hfd);
      c = count;
      repeat (100) @(negedge clk_in);
      check("running in standby", running, 0);
      check("count kept in standby", (count == c) && (c > 8'h05), 1);
      cw(8'h00, 8'hfa);
      check("running after counter reset", running, 0);
      check("count under counter reset", count, 0);
      cw(8'h00, 8'hfa);
      repeat (100) @(negedge clk_in);
      check("no launch under counter reset", running, 0);
      check("no steps under counter reset", count, 0);
   endtask
   initial begin
      repeat (5) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (6) @(negedge clk_in);
      t_regs();
      t_holds();
      t_full();
      t_home();
      t_abort();
      end_sim();
   end
   initial begin
      #2_000_000;
      n_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
